// ===== design/hsd_params.svh
// Constants for the homing subcommand decoder
`ifndef HSD_PARAMS_SVH
`define HSD_PARAMS_SVH
// Register byte offsets
`define HSD_OFF_CTRL 8'h00
`define HSD_OFF_CMD 8'h04
`define HSD_OFF_RES 8'h08
`define HSD_OFF_STAT 8'h0C
`define HSD_OFF_ACT 8'h10
`define HSD_OFF_CPOS 8'h14
`define HSD_OFF_EXT 8'h18
`define HSD_OFF_ISTAT 8'h1C
`define HSD_OFF_IMASK 8'h20
// Control field positions
`define HSD_B_SERVO 0
`define HSD_B_FB_LO 1
`define HSD_B_FB_HI 3
`define HSD_B_PPM 4
`define HSD_B_STURN 5
`define HSD_B_EXTMON 6
`define HSD_B_L1IDX 7
`define HSD_B_L2IDX 8
`define HSD_CTRL_RST 9'h010
// Feedback configurations
`define HSD_FB_SEMI_INC 3'h0
`define HSD_FB_SEMI_ABS 3'h1
`define HSD_FB_FULL_REL 3'h2
`define HSD_FB_FULL_QUAD 3'h3
`define HSD_FB_FULL_ABS 3'h4
// Subtype codes
`define HSD_C_ZPH 8'h11
`define HSD_C_EDGE_LAST 8'h1D
`define HSD_C_ACT_SET 8'h21
`define HSD_C_CMD_SET 8'h22
`define HSD_C_MT_CLR 8'h31
`define HSD_C_MON 8'h50
`define HSD_C_ARM1 8'h51
`define HSD_C_ARM2 8'h52
`define HSD_C_ARM12 8'h53
`define HSD_C_DIS1 8'h54
`define HSD_C_DIS2 8'h58
`define HSD_C_DIS12 8'h5C
`define HSD_C_STOP1 8'hF1
// Command error codes
`define HSD_ERR_NONE 16'h0000
`define HSD_ERR_CODE 16'h0031
`define HSD_ERR_STURN 16'h0051
`define HSD_ERR_NOIDX 16'h005A
`define HSD_ERR_UNSUP 16'h0101
`define HSD_ERR_STATE 16'h0102
// Interrupt bits
`define HSD_I_ERR 0
`define HSD_I_OK 1
`define HSD_I_INIT 2
`endif

// ===== design/hsd_pkg.sv
// Types shared by the homing subcommand decoder
`default_nettype none
package hsd_pkg;
    typedef enum logic {HSD_IDLE, HSD_WAIT} state_type;
    typedef struct packed {
        logic [15:0] err;
        logic init;
        logic wait_edge;
        logic mt;
        logic [1:0] arm;
        logic [1:0] dis;
    } dec_type;
endpackage : hsd_pkg
`default_nettype wire

// ===== design/hsd_top.sv
// Homing subcommand decoder with APB registers
//
// Chosen here: register access over APB and the placing of the registers.
`default_nettype none
`include "hsd_params.svh"
module hsd_top (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [6:0] REF_PIN,
    output logic IRQ,
    output logic LATCH1_ARMED,
    output logic LATCH2_ARMED,
    output logic MT_CLEAR,
    output logic POS_INIT
);
    // Pin 0 index, 1 home, 2 fwd_overtravel_inhibit, 3 rev, 4..6 aux_input_a..c
    logic [6:0] s1_q, s2_q, s3_q, filt_q, filt_d;
    logic [6:0] rise, fall;
    logic [8:0] ctrl_q, ctrl_d;
    logic [31:0] act_q, act_d, cpos_q, cpos_d, ext_q, ext_d;
    logic [2:0] ist_q, ist_d, imask_q, imask_d;
    logic [15:0] err_q, err_d;
    logic [7:0] code_q, code_d;
    logic [1:0] arm_q, arm_d;
    logic [2:0] sel_q, sel_d;
    logic pol_q, pol_d, mt_q, mt_d, init_q, init_d, irq_q, irq_d;
    logic rdy_q, rdy_d, slv_q, slv_d;
    logic [31:0] rd_q, rd_d;
    hsd_pkg::state_type st_q, st_d;
    hsd_pkg::dec_type dec;
    logic commit, cmd_go, mapped, hit, do_init, semi;

    // Offset decode, used only by the error answer; the read mux decodes PADDR itself
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `HSD_OFF_CTRL) || (a == `HSD_OFF_CMD) || (a == `HSD_OFF_RES)
            || (a == `HSD_OFF_STAT) || (a == `HSD_OFF_ACT) || (a == `HSD_OFF_CPOS)
            || (a == `HSD_OFF_EXT) || (a == `HSD_OFF_ISTAT) || (a == `HSD_OFF_IMASK);
    endfunction : is_mapped

    // Decide one subtype code against the present configuration
    function automatic hsd_pkg::dec_type decide(input logic [7:0] c, input logic [8:0] k);
        hsd_pkg::dec_type r;
        logic son, ppm, abs_fb;
        son = k[`HSD_B_SERVO];
        ppm = k[`HSD_B_PPM];
        abs_fb = (k[`HSD_B_FB_HI:`HSD_B_FB_LO] == `HSD_FB_FULL_ABS);
        r = '0;
        r.err = `HSD_ERR_NONE;
        if (c >= `HSD_C_ZPH && c <= `HSD_C_EDGE_LAST) begin
            if (ppm) begin
                r.err = `HSD_ERR_UNSUP;
            end else if (!son) begin
                r.err = `HSD_ERR_STATE;
            end else begin
                r.wait_edge = 1'b1;
            end
        end else begin
            case (c)
                `HSD_C_ACT_SET, `HSD_C_CMD_SET: r.init = 1'b1;
                `HSD_C_MT_CLR: begin
                    if (k[`HSD_B_STURN]) begin
                        r.err = `HSD_ERR_STURN;
                    end else if (k[`HSD_B_FB_HI:`HSD_B_FB_LO] != `HSD_FB_SEMI_ABS || son) begin
                        r.err = `HSD_ERR_STATE;
                    end else begin
                        r.init = 1'b1;
                        r.mt = 1'b1;
                    end
                end
                `HSD_C_MON: r.init = 1'b0;
                `HSD_C_ARM1: r.arm = 2'h1;
                `HSD_C_ARM2: r.arm = 2'h2;
                `HSD_C_ARM12: r.arm = 2'h3;
                `HSD_C_DIS1: r.dis = 2'h1;
                `HSD_C_DIS2: r.dis = 2'h2;
                `HSD_C_DIS12: r.dis = 2'h3;
                `HSD_C_STOP1: begin
                    if (ppm) begin
                        r.err = `HSD_ERR_UNSUP;
                    end else if (!son) begin
                        r.err = `HSD_ERR_STATE;
                    end else begin
                        r.arm = 2'h1;
                    end
                end
                default: r.err = `HSD_ERR_CODE;
            endcase
        end
        // No index pulse on this scale, so an index trigger cannot be honoured
        if (abs_fb && ((r.arm[0] && k[`HSD_B_L1IDX]) || (r.arm[1] && k[`HSD_B_L2IDX])
                || (c == `HSD_C_MON && (k[`HSD_B_L1IDX] || k[`HSD_B_L2IDX])))) begin
            r.err = `HSD_ERR_NOIDX;
            r.arm = 2'h0;
        end
        decide = r;
    endfunction : decide

    // Pin synchroniser: a change counts once stages two and three agree
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s1_q <= 7'h00;
            s2_q <= 7'h00;
            s3_q <= 7'h00;
            filt_q <= 7'h00;
        end else begin
            s1_q <= REF_PIN;
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= filt_d;
        end
    end

    // Agreed level and its logical edges
    always_comb begin
        filt_d = filt_q;
        rise = 7'h00;
        fall = 7'h00;
        for (int i = 0; i < 7; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                filt_d[i] = s3_q[i];
                rise[i] = s3_q[i] & ~filt_q[i];
                fall[i] = ~s3_q[i] & filt_q[i];
            end
        end
    end

    // Bus phases; the one wait state gives time to register read data
    assign commit = PSEL && PENABLE && rdy_q;
    assign cmd_go = commit && PWRITE && (PADDR == `HSD_OFF_CMD);
    assign mapped = is_mapped(PADDR);
    assign dec = decide(PWDATA[7:0], ctrl_q);
    assign semi = (ctrl_q[`HSD_B_FB_HI:`HSD_B_FB_LO] == `HSD_FB_SEMI_INC)
        || (ctrl_q[`HSD_B_FB_HI:`HSD_B_FB_LO] == `HSD_FB_SEMI_ABS);
    assign hit = (st_q == hsd_pkg::HSD_WAIT) && (pol_q ? rise[sel_q] : fall[sel_q]);
    assign do_init = hit || (cmd_go && dec.init && dec.err == `HSD_ERR_NONE);

    // APB answer path
    always_comb begin
        rdy_d = PSEL && PENABLE && !rdy_q;
        slv_d = rdy_d && !mapped;
        rd_d = 32'h00000000;
        if (rdy_d && !PWRITE) begin
            case (PADDR)
                `HSD_OFF_CTRL: rd_d = {23'h000000, ctrl_q};
                `HSD_OFF_RES: rd_d = {8'h00, code_q, err_q};
                `HSD_OFF_STAT: rd_d = {28'h0000000, st_q == hsd_pkg::HSD_WAIT, 1'b0, arm_q};
                `HSD_OFF_ACT: rd_d = act_q;
                `HSD_OFF_CPOS: rd_d = cpos_q;
                `HSD_OFF_EXT: rd_d = ext_q;
                `HSD_OFF_ISTAT: rd_d = {29'h00000000, ist_q};
                `HSD_OFF_IMASK: rd_d = {29'h00000000, imask_q};
                default: rd_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdy_q <= 1'b0;
            slv_q <= 1'b0;
            rd_q <= 32'h00000000;
        end else begin
            rdy_q <= rdy_d;
            slv_q <= slv_d;
            rd_q <= rd_d;
        end
    end

    // Command core, positions and interrupt state
    always_comb begin
        ctrl_d = ctrl_q;
        act_d = act_q;
        cpos_d = cpos_q;
        ext_d = ext_q;
        imask_d = imask_q;
        err_d = err_q;
        code_d = code_q;
        arm_d = arm_q;
        st_d = st_q;
        sel_d = sel_q;
        pol_d = pol_q;
        mt_d = 1'b0;
        init_d = 1'b0;
        ist_d = ist_q;
        if (commit && PWRITE) begin
            case (PADDR)
                `HSD_OFF_CTRL: ctrl_d = PWDATA[8:0];
                `HSD_OFF_ACT: act_d = PWDATA;
                `HSD_OFF_CPOS: cpos_d = PWDATA;
                `HSD_OFF_EXT: ext_d = PWDATA;
                `HSD_OFF_ISTAT: ist_d = ist_q & ~PWDATA[2:0];
                `HSD_OFF_IMASK: imask_d = PWDATA[2:0];
                default: ist_d = ist_q;
            endcase
        end
        if (cmd_go) begin
            code_d = PWDATA[7:0];
            err_d = dec.err;
            // A new command always ends any pending edge wait
            st_d = hsd_pkg::HSD_IDLE;
            if (dec.err == `HSD_ERR_NONE) begin
                arm_d = (arm_q & ~dec.dis) | dec.arm;
                mt_d = dec.mt;
                ist_d[`HSD_I_OK] = 1'b1;
                if (dec.wait_edge) begin
                    st_d = hsd_pkg::HSD_WAIT;
                    // 11h watches the index; later pairs map onto pins 1..6
                    sel_d = (PWDATA[7:0] == `HSD_C_ZPH) ? 3'h0
                        : 3'((PWDATA[7:0] - `HSD_C_ZPH - 8'h01) >> 1) + 3'h1;
                    pol_d = (PWDATA[7:0] == `HSD_C_ZPH) || !PWDATA[0];
                end
            end else begin
                ist_d[`HSD_I_ERR] = 1'b1;
            end
        end
        if (hit) begin
            st_d = hsd_pkg::HSD_IDLE;
        end
        if (do_init) begin
            act_d = 32'h00000000;
            cpos_d = 32'h00000000;
            if (!(semi && ctrl_q[`HSD_B_EXTMON])) begin
                ext_d = 32'h00000000;
            end
            init_d = 1'b1;
            ist_d[`HSD_I_INIT] = 1'b1; // Set wins over a clear in the same cycle
        end
        irq_d = |(ist_d & imask_d);
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q <= `HSD_CTRL_RST;
            act_q <= 32'h00000000;
            cpos_q <= 32'h00000000;
            ext_q <= 32'h00000000;
            imask_q <= 3'h0;
            ist_q <= 3'h0;
            err_q <= `HSD_ERR_NONE;
            code_q <= 8'h00;
            arm_q <= 2'h0;
            st_q <= hsd_pkg::HSD_IDLE;
            sel_q <= 3'h0;
            pol_q <= 1'b0;
            mt_q <= 1'b0;
            init_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            act_q <= act_d;
            cpos_q <= cpos_d;
            ext_q <= ext_d;
            imask_q <= imask_d;
            ist_q <= ist_d;
            err_q <= err_d;
            code_q <= code_d;
            arm_q <= arm_d;
            st_q <= st_d;
            sel_q <= sel_d;
            pol_q <= pol_d;
            mt_q <= mt_d;
            init_q <= init_d;
            irq_q <= irq_d;
        end
    end

    // Outputs straight from flip-flops
    assign PRDATA = rd_q;
    assign PREADY = rdy_q;
    assign PSLVERR = slv_q;
    assign IRQ = irq_q;
    assign LATCH1_ARMED = arm_q[0];
    assign LATCH2_ARMED = arm_q[1];
    assign MT_CLEAR = mt_q;
    assign POS_INIT = init_q;

    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence code_in(logic [7:0] c);
        cmd_go && PWDATA[7:0] == c;
    endsequence

    unknown_code_a: assert property (code_in(8'h60) |=> err_q == 16'h0031)
        else $error("undefined code not refused");
    rise_trigger_a: assert property (st_q == hsd_pkg::HSD_WAIT && code_q == 8'h18 && !cmd_go
        |=> POS_INIT == $past(rise[4]) && (!POS_INIT || act_q == 32'h00000000))
        else $error("rising edge trigger mismatch");
    fall_trigger_a: assert property (st_q == hsd_pkg::HSD_WAIT && code_q == 8'h19 && !cmd_go
        |=> POS_INIT == $past(fall[4]))
        else $error("falling edge trigger mismatch");
    pp_refuse_a: assert property ((code_in(8'h11) or code_in(8'hF1)) ##0 ctrl_q[4]
        |=> err_q == 16'h0101 && st_q == hsd_pkg::HSD_IDLE && !POS_INIT)
        else $error("profile position mode accepted an edge code");
    monitor_keep_a: assert property (code_in(8'h50) ##0 !ctrl_q[7] && !ctrl_q[8]
        |=> err_q == 16'h0000 && act_q == $past(act_q) && cpos_q == $past(cpos_q))
        else $error("monitor code not accepted or moved positions");
    arm_both_a: assert property (code_in(8'h53) ##0 !ctrl_q[7] && !ctrl_q[8]
        |=> LATCH1_ARMED && LATCH2_ARMED)
        else $error("latch channels not armed");
    disarm_both_a: assert property (code_in(8'h5C) |=> (!LATCH1_ARMED && !LATCH2_ARMED)[*2])
        else $error("latch channels not disarmed");
    no_index_a: assert property (code_in(8'h51) ##0 ctrl_q[3:1] == 3'h4 && ctrl_q[7]
        |=> err_q == 16'h005A && LATCH1_ARMED == $past(LATCH1_ARMED))
        else $error("index trigger accepted on absolute scale");
    single_turn_a: assert property (code_in(8'h31) ##0 ctrl_q[5]
        |=> err_q == 16'h0051 && !MT_CLEAR)
        else $error("multi-turn clear with single-turn enabled");
    ext_keep_a: assert property (POS_INIT && $past(semi && ctrl_q[6])
        |-> ext_q == $past(ext_q))
        else $error("monitored scale position cleared");
    pos_set_a: assert property (code_in(8'h22) |=> POS_INIT
        && act_q == 32'h00000000 && cpos_q == 32'h00000000)
        else $error("position set not applied");
    mt_state_a: assert property (code_in(8'h31) ##0 !ctrl_q[5] && ctrl_q[0]
        |=> err_q == 16'h0102 && !MT_CLEAR)
        else $error("multi-turn clear with servo on");
endmodule : hsd_top
`default_nettype wire

// ===== verification/hsd_host_model.sv
// Host controller model: APB master and reference sensor levels
`default_nettype none
module hsd_host_model (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic [6:0] ref_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus and quiet sensors from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        ref_pin = 7'h00;
    end

    // One APB transfer; entry waits an edge so no signal is set twice in one step
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Wait as long as the slave needs; only the bench watchdog ends a dead wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    // Sensor level change, launched just after an edge
    task automatic set_ref(input int i, input logic v);
        @(posedge clk);
        ref_pin[i] <= v;
    endtask : set_ref
endmodule : hsd_host_model
`default_nettype wire

// ===== verification/hsd_top_tb.sv
// Self-checking bench for the homing subcommand decoder
`default_nettype none
`include "hsd_params.svh"
module hsd_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, l1, l2, mt_clear, pos_init;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic [6:0] ref_pin;
    logic pi_q, mc_q, e_q;
    int err_count = 0;
    int cmp_count = 0;

    hsd_host_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_pin(ref_pin));
    hsd_top dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .REF_PIN(ref_pin), .IRQ(irq), .LATCH1_ARMED(l1), .LATCH2_ARMED(l2),
        .MT_CLEAR(mt_clear), .POS_INIT(pos_init));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk32(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk32

    task automatic chk1(input string nm, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %b seen %b", nm, exp, got);
        end
    endtask : chk1

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd_q, e_q);
    endtask : wr

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0000_0000, rd_q, e_q);
        chk32(nm, exp, rd_q);
    endtask : rd

    // Issue a code, catch the one-cycle pulses, then check the error field
    task automatic cmd(input logic [7:0] code, input logic [15:0] exp_err);
        wr(`HSD_OFF_CMD, {24'h00_0000, code});
        #1;
        pi_q = pos_init;
        mc_q = mt_clear;
        host.xfer(1'b0, `HSD_OFF_RES, 32'h0000_0000, rd_q, e_q);
        chk32("result", {16'h0000, exp_err}, {16'h0000, rd_q[15:0]});
    endtask : cmd

    // Bounded watch for the init pulse after a sensor edge
    task automatic watch_init(input int n, input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge clk);
            #1;
            seen = seen | pos_init;
        end
        chk1("pos_init", exp, seen);
    endtask : watch_init

    task automatic wrap_up;
        $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    // Watchdog: run needs a few hundred cycles, limit is 20000
    initial begin
        #400000;
        err_count++;
        wrap_up();
    end

    initial begin
        rst_n = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        // Reset value and unmapped access
        rd("ctrl", `HSD_OFF_CTRL, 32'h0000_0010);
        host.xfer(1'b0, 8'h40, 32'h0000_0000, rd_q, e_q);
        chk1("pslverr", 1'b1, e_q);
        chk32("unmapped", 32'h0000_0000, rd_q);
        $display("Test reset and bus done");
        // Undefined codes and profile position refusals
        cmd(8'h40, 16'h0031);
        cmd(8'h00, 16'h0031);
        for (int c = 8'h11; c <= 8'h1D; c++) begin
            cmd(c[7:0], `HSD_ERR_UNSUP);
        end
        wr(`HSD_OFF_CTRL, 32'h0000_0011);
        cmd(8'hF1, `HSD_ERR_UNSUP);
        chk1("latch1", 1'b0, l1);
        $display("Test refusals done");
        // Position set codes, servo on then off
        wr(`HSD_OFF_ACT, 32'h0000_0005);
        wr(`HSD_OFF_CPOS, 32'h0000_0009);
        cmd(8'h21, `HSD_ERR_NONE);
        chk1("pos_init", 1'b1, pi_q);
        rd("act", `HSD_OFF_ACT, 32'h0000_0000);
        rd("cpos", `HSD_OFF_CPOS, 32'h0000_0000);
        wr(`HSD_OFF_CTRL, 32'h0000_0018);
        wr(`HSD_OFF_ACT, 32'h0000_0005);
        cmd(8'h22, `HSD_ERR_NONE);
        rd("act", `HSD_OFF_ACT, 32'h0000_0000);
        // Latch codes leave positions alone
        wr(`HSD_OFF_ACT, 32'h0000_0007);
        cmd(8'h50, `HSD_ERR_NONE);
        chk1("pos_init", 1'b0, pi_q);
        cmd(8'h53, `HSD_ERR_NONE);
        chk1("latch1", 1'b1, l1);
        chk1("latch2", 1'b1, l2);
        cmd(8'h54, `HSD_ERR_NONE);
        chk1("latch1", 1'b0, l1);
        chk1("latch2", 1'b1, l2);
        cmd(8'h58, `HSD_ERR_NONE);
        chk1("latch2", 1'b0, l2);
        wr(`HSD_OFF_CTRL, 32'h0000_0011);
        cmd(8'h51, `HSD_ERR_NONE);
        cmd(8'h52, `HSD_ERR_NONE);
        chk1("latch1", 1'b1, l1);
        chk1("latch2", 1'b1, l2);
        cmd(8'h5C, `HSD_ERR_NONE);
        chk1("latch1", 1'b0, l1);
        chk1("latch2", 1'b0, l2);
        rd("act", `HSD_OFF_ACT, 32'h0000_0007);
        // Serial absolute scale with index trigger
        wr(`HSD_OFF_CTRL, 32'h0000_0098);
        cmd(8'h51, `HSD_ERR_NOIDX);
        chk1("latch1", 1'b0, l1);
        $display("Test latch codes done");
        // Multi-turn clear: allowed, single-turn, wrong feedback, servo on
        wr(`HSD_OFF_CTRL, 32'h0000_0012);
        cmd(8'h31, `HSD_ERR_NONE);
        chk1("mt_clear", 1'b1, mc_q);
        wr(`HSD_OFF_CTRL, 32'h0000_0032);
        cmd(8'h31, `HSD_ERR_STURN);
        chk1("mt_clear", 1'b0, mc_q);
        wr(`HSD_OFF_CTRL, 32'h0000_0010);
        cmd(8'h31, `HSD_ERR_STATE);
        wr(`HSD_OFF_CTRL, 32'h0000_0013);
        cmd(8'h31, `HSD_ERR_STATE);
        chk1("mt_clear", 1'b0, mc_q);
        $display("Test multi-turn done");
        // Edge-triggered homing outside profile position mode
        wr(`HSD_OFF_CTRL, 32'h0000_0001);
        cmd(8'h18, `HSD_ERR_NONE);
        rd("stat", `HSD_OFF_STAT, 32'h0000_0008);
        host.set_ref(5, 1'b1);
        watch_init(12, 1'b0);
        host.set_ref(4, 1'b1);
        watch_init(12, 1'b1);
        cmd(8'h19, `HSD_ERR_NONE);
        host.set_ref(5, 1'b0);
        watch_init(12, 1'b0);
        host.set_ref(4, 1'b0);
        watch_init(12, 1'b1);
        cmd(8'hF1, `HSD_ERR_NONE);
        chk1("latch1", 1'b1, l1);
        cmd(8'h5C, `HSD_ERR_NONE);
        wr(`HSD_OFF_CTRL, 32'h0000_0000);
        cmd(8'h12, `HSD_ERR_STATE);
        $display("Test edge homing done");
        // External scale position kept only under semi-closed monitoring
        wr(`HSD_OFF_CTRL, 32'h0000_0041);
        wr(`HSD_OFF_EXT, 32'h0000_0007);
        cmd(8'h21, `HSD_ERR_NONE);
        rd("ext", `HSD_OFF_EXT, 32'h0000_0007);
        wr(`HSD_OFF_CTRL, 32'h0000_0005);
        cmd(8'h21, `HSD_ERR_NONE);
        rd("ext", `HSD_OFF_EXT, 32'h0000_0000);
        $display("Test scale monitor done");
        // Interrupt: clear, mask open, masked event
        wr(`HSD_OFF_ISTAT, 32'h0000_0007);
        wr(`HSD_OFF_IMASK, 32'h0000_0001);
        #1;
        chk1("irq", 1'b0, irq);
        cmd(8'h40, `HSD_ERR_CODE);
        chk1("irq", 1'b1, irq);
        wr(`HSD_OFF_ISTAT, 32'h0000_0001);
        #1;
        chk1("irq", 1'b0, irq);
        wr(`HSD_OFF_IMASK, 32'h0000_0000);
        cmd(8'h41, `HSD_ERR_CODE);
        chk1("irq", 1'b0, irq);
        rd("istat", `HSD_OFF_ISTAT, 32'h0000_0001);
        $display("Test interrupt done");
        wrap_up();
    end
endmodule : hsd_top_tb
`default_nettype wire
